// ---- logic/ces_map.svh ----
// offsets, reset value, unmapped read value and channel count of the channel enable bank
`ifndef CES_MAP_SVH
`define CES_MAP_SVH
`define CES_OFF_ENABLE 12'h500
`define CES_OFF_SET 12'h504
`define CES_ENABLE_RESET 32'h00000000
`define CES_UNMAPPED_READ 32'h00000000
`define CES_CHANNELS 32
`endif

// ---- logic/ces_pkg.sv ----
// types shared by the channel enable bank
package ces_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } ces_wb_req_type;
endpackage : ces_pkg

// ---- logic/ces_bank.sv ----
// channel enable bank with its set alias, as a classic wishbone slave
// How it works
// [R1] one read-write enable bit per channel, bit index equals channel, 1 enabled
// [R2] set alias decoded at offset 0x504
// [R3] reading the set alias returns the current enable bits
// [R4] writing 1 into a set alias bit enables that channel
// [R5] writing 0 into a set alias bit leaves that channel unchanged
// [R6] set alias covers all 32 channels, each at its own bit position
// [R7] main enable register decoded at 0x500, directly readable and writable
// [R8] reset clears every enable bit, all channels start disabled
`timescale 1ns/1ps
`include "ces_map.svh"
module ces_bank
  import ces_pkg::*;
#(
  parameter int NUM_CH = `CES_CHANNELS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [NUM_CH-1:0] channel_enable
);
  ces_wb_req_type req;
  logic [NUM_CH-1:0] channel_enable_reg;
  logic [NUM_CH-1:0] channel_enable_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [3:0] lane_sel;
  logic [31:0] lane_mask;

  // bus pins gathered into one request word; the low address bits select nothing
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: {wb_adr_i[11:2], 2'b00}, dat: wb_dat_i};

  // a new request is taken only while ack is low, so a held request is not taken twice
  wire take = req.cyc && req.stb && !ack_reg;
  wire wr_take = take && req.we;
  wire rd_take = take && !req.we;

  // address decode
  wire hit_enable = req.adr == `CES_OFF_ENABLE; // [R7]
  wire hit_set = req.adr == `CES_OFF_SET; // [R2]
  wire hit_any = hit_enable || hit_set;

  // byte lanes: each select bit opens eight bits of the write data
  assign lane_sel = req.sel;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_mask[8*g+7:8*g] = {8{lane_sel[g]}};
    end
  endgenerate

  // enables widened to the bus word; bits above the channel count read zero
  wire [31:0] cur_word = 32'(channel_enable_reg);
  wire [31:0] wr_bits = req.dat & lane_mask;
  // direct write replaces selected lanes; alias write only ors ones in
  wire [31:0] direct_word = (cur_word & ~lane_mask) | wr_bits; // [R1]
  wire [31:0] set_word = cur_word | wr_bits; // [R4] [R5] [R6]
  wire [31:0] wr_word = hit_enable ? direct_word : (hit_set ? set_word : cur_word);
  // both offsets read back the live enables; unmapped reads give zero
  wire [31:0] rd_word = hit_any ? cur_word : `CES_UNMAPPED_READ; // [R3]

  assign channel_enable_next = wr_take ? wr_word[NUM_CH-1:0] : channel_enable_reg;
  assign ack_next = take;
  // read data stands only in the ack cycle, so a stale word is never taken for data
  assign dat_next = rd_take ? rd_word : 32'h00000000;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      channel_enable_reg <= NUM_CH'(`CES_ENABLE_RESET); // [R8]
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      channel_enable_reg <= channel_enable_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign channel_enable = channel_enable_reg;

  // reset checks look one edge on, so they never see power-up unknowns
  a_reset_clears: assert property ( // [R8]
    @(posedge clk_sys)
    srst
    |=> channel_enable_reg == '0)
    else $error("enables not cleared by reset");

  a_reset_quiet: assert property ( // [R8]
    @(posedge clk_sys)
    srst
    |=> !wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("bus outputs not quiet in reset");

  a_set_keeps_ones: assert property ( // [R5]
    @(posedge clk_sys) disable iff (srst)
    (wr_take && hit_set)
    |=> (channel_enable_reg & $past(channel_enable_reg)) == $past(channel_enable_reg))
    else $error("set alias write cleared a channel");

  a_set_sets_bits: assert property ( // [R4]
    @(posedge clk_sys) disable iff (srst)
    (wr_take && hit_set && wb_sel_i == 4'hf)
    |=> channel_enable_reg == ($past(channel_enable_reg) | $past(wb_dat_i[NUM_CH-1:0])))
    else $error("set alias write did not set bits");

  a_set_lane_skip: assert property ( // [R5]
    @(posedge clk_sys) disable iff (srst)
    (wr_take && hit_set && !wb_sel_i[0])
    |=> channel_enable_reg[7:0] == $past(channel_enable_reg[7:0]))
    else $error("set alias changed an unselected lane");

  a_set_top_channel: assert property ( // [R6]
    @(posedge clk_sys) disable iff (srst)
    (wr_take && hit_set && wb_sel_i[3] && wb_dat_i[NUM_CH-1])
    |=> channel_enable_reg[NUM_CH-1])
    else $error("top channel not set through alias");

  a_direct_write: assert property ( // [R1] [R7]
    @(posedge clk_sys) disable iff (srst)
    (wr_take && hit_enable && wb_sel_i == 4'hf)
    |=> channel_enable_reg == $past(wb_dat_i[NUM_CH-1:0]))
    else $error("direct write not stored");

  a_direct_lane_keep: assert property ( // [R1]
    @(posedge clk_sys) disable iff (srst)
    (wr_take && hit_enable && !wb_sel_i[0])
    |=> channel_enable_reg[7:0] == $past(channel_enable_reg[7:0]))
    else $error("direct write changed an unselected lane");

  a_direct_clears: assert property ( // [R1]
    @(posedge clk_sys) disable iff (srst)
    (wr_take && hit_enable && wb_sel_i[0] && !wb_dat_i[0])
    |=> !channel_enable_reg[0])
    else $error("direct write of zero left channel enabled");

  a_alias_read: assert property ( // [R3]
    @(posedge clk_sys) disable iff (srst)
    (rd_take && hit_set)
    |=> wb_ack_o && wb_dat_o == 32'($past(channel_enable_reg)))
    else $error("alias read mismatch");

  a_enable_read: assert property ( // [R7]
    @(posedge clk_sys) disable iff (srst)
    (rd_take && hit_enable)
    |=> wb_dat_o == 32'($past(channel_enable_reg)))
    else $error("enable read mismatch");

  a_alias_decode: assert property ( // [R2]
    @(posedge clk_sys) disable iff (srst)
    (wr_take && !hit_any)
    |=> $stable(channel_enable_reg))
    else $error("unmapped write changed enables");

  a_unmapped_read: assert property ( // [R2]
    @(posedge clk_sys) disable iff (srst)
    (rd_take && !hit_any)
    |=> wb_dat_o == `CES_UNMAPPED_READ)
    else $error("unmapped read not zero");

  a_read_no_change: assert property ( // [R3]
    @(posedge clk_sys) disable iff (srst)
    rd_take
    |=> $stable(channel_enable_reg))
    else $error("read changed enables");

  // handshake: one ack per taken request, never more
  a_ack_follows: assert property (
    @(posedge clk_sys) disable iff (srst)
    take
    |=> wb_ack_o)
    else $error("taken request not acked");

  a_ack_one_cycle: assert property (
    @(posedge clk_sys) disable iff (srst)
    wb_ack_o
    |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_no_stray_ack: assert property (
    @(posedge clk_sys) disable iff (srst)
    !take
    |=> !wb_ack_o)
    else $error("ack without a request");

  a_dat_idle_zero: assert property (
    @(posedge clk_sys) disable iff (srst)
    !wb_ack_o
    |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack cycle");

  a_no_idle_change: assert property ( // [R1]
    @(posedge clk_sys) disable iff (srst)
    !wr_take
    |=> $stable(channel_enable_reg))
    else $error("enables changed without write");
endmodule : ces_bank

// ---- testbench/tb.sv ----
// self-checking bench for the channel enable bank
`timescale 1ns/1ps
`include "ces_map.svh"
module tb;
  import ces_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  ces_wb_req_type rq = '0;
  logic [31:0] dat_o, en, rd;
  logic ack;
  int err_total = 0;
  int n_checks = 0;
  // rows: address, write data, enable vector expected afterwards
  logic [75:0] rows [6] = '{{12'h500, 32'h000000f0, 32'h000000f0},
    {12'h504, 32'h80000001, 32'h800000f1}, {12'h504, 32'h00000000, 32'h800000f1},
    {12'h7fc, 32'hffffffff, 32'h800000f1}, {12'h500, 32'h00000003, 32'h00000003},
    {12'h504, 32'hffffffff, 32'hffffffff}};
  ces_bank i_dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(rq.cyc), .wb_stb_i(rq.stb),
    .wb_we_i(rq.we), .wb_sel_i(rq.sel), .wb_adr_i(rq.adr), .wb_dat_i(rq.dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .channel_enable(en));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic close_out;
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // one classic cycle; released at the ack edge so cyc is low for a cycle after
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
    int k;
    rq <= '{1'b1, 1'b1, w, s, a, d};
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (ack === 1'b1) break;
    end
    rd = dat_o;
    if (k == 20) begin
      err_total++;
      close_out();
    end
    rq <= '0;
    @(posedge clk_sys);
  endtask : bus
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    cmp(en, 32'h0);
    cmp(dat_o, 32'h0);
    cmp({31'h0, ack}, 32'h0);
    srst <= 1'b0;
    @(posedge clk_sys);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][75:64], rows[i][63:32]);
      cmp(en, rows[i][31:0]);
      bus(1'b0, `CES_OFF_ENABLE, 32'h0);
      cmp(rd, rows[i][31:0]);
      bus(1'b0, `CES_OFF_SET, 32'h0);
      cmp(rd, rows[i][31:0]);
      cmp(dat_o, 32'h0);
    end
    bus(1'b0, 12'h7fc, 32'h0);
    cmp(rd, `CES_UNMAPPED_READ);
    // byte lanes: unselected lanes neither change nor get set
    bus(1'b1, `CES_OFF_ENABLE, 32'h0, 4'hf);
    cmp(en, 32'h0);
    bus(1'b1, `CES_OFF_SET, 32'hffffffff, 4'h2);
    cmp(en, 32'h0000ff00);
    bus(1'b1, `CES_OFF_ENABLE, 32'h000000ff, 4'h1);
    cmp(en, 32'h0000ffff);
    bus(1'b1, `CES_OFF_SET, 32'hffffffff, 4'hf);
    // a second reset in mid-run must clear an all-enabled vector
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    cmp(en, 32'h0);
    close_out();
  end
endmodule : tb
